// ==== src/qadc_pkg.sv ====
// Shared constants for the four-channel converter readout: widths, timing, host register map.
// Assumes a single 250 MHz core_clk shared by both ends of the link.
package qadc_pkg;

  // Data path shape.
  localparam int CH_N = 4;
  localparam int DATA_W = 14;
  localparam int WORD_W = 16;
  localparam int PACK_W = 32;
  localparam int CH_IDX_W = 2;
  localparam int SYNC_STAGES = 3;

  // Clock period in picoseconds (4 ns).
  localparam int CLK_PS = 4000;

  // Converter timing, each held as a time and derived into cycles.
  localparam int CONV_NS = 400;
  localparam int CONV_CYCLES = (CONV_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int EOC_LOW_NS = 40;
  localparam int EOC_LOW_CYCLES = (EOC_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int DATA_HOLD_NS = 16;
  localparam int DATA_HOLD_CYCLES = (DATA_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;

  // Host read strobe and frame sync timing.
  localparam int RD_LOW_NS = 40;
  localparam int RD_LOW_CYCLES = (RD_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RD_HIGH_NS = 40;
  localparam int RD_HIGH_CYCLES = (RD_HIGH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int FS_LOW_NS = 20;
  localparam int FS_LOW_CYCLES = (FS_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;

  // Counter widths.
  localparam int CNT_W = 8;
  localparam int DIV_W = 16;
  localparam logic [CNT_W-1:0] CONV_CNT = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] EOC_CNT = CNT_W'(EOC_LOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(DATA_HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] RDL_CNT = CNT_W'(RD_LOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] RDH_CNT = CNT_W'(RD_HIGH_CYCLES - 1);
  localparam logic [DIV_W-1:0] FS_LOW_CNT = DIV_W'(FS_LOW_CYCLES);

  // All four channels selected by the hardware select pins.
  localparam logic [CH_N-1:0] CH_ALL = 4'hf;

  // Host register map (byte addresses).
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_DIV = 8'h04;
  localparam logic [ADDR_W-1:0] REG_TXBUF = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STEP = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] REG_RES0 = 8'h18;
  localparam logic [ADDR_W-1:0] REG_RES1 = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_RES2 = 8'h20;
  localparam logic [ADDR_W-1:0] REG_RES3 = 8'h24;

  // Field positions.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CAP_BIT = 1;
  localparam int ST_SEQ_BIT = 0;
  localparam int ST_XFER_BIT = 1;
  localparam int ST_W = 2;

  // Reset values.
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h0100;
  localparam logic STEP_RESET = 1'b1;

endpackage

// ==== src/qadc_link_if.sv ====
// Board wiring between the converter and the host: one modport per end.
// Assumes both ends run on the same core_clk; the bus resolves the data lines here.
`timescale 1ns/1ps
`default_nettype none
interface qadc_link_if;
  import qadc_pkg::*;

  logic conversion_start_n;
  logic [CH_N-1:0] channel_select_pins;
  logic cs_n;
  logic host_rd_n;
  logic capture_wiring;
  logic eoc_n;
  logic busy;
  logic [DATA_W-1:0] dev_data;
  logic dev_data_oe;
  logic rd_n;
  logic [DATA_W-1:0] data;

  // In the capture scheme the end strobe is wired to the converter read input.
  assign rd_n = capture_wiring ? eoc_n : host_rd_n;
  // Undriven data lines float high, as with weak pull-ups.
  assign data = dev_data_oe ? dev_data : '1;

  modport device (
    input conversion_start_n,
    input channel_select_pins,
    input cs_n,
    input rd_n,
    output eoc_n,
    output busy,
    output dev_data,
    output dev_data_oe
  );

  modport host (
    output conversion_start_n,
    output channel_select_pins,
    output cs_n,
    output host_rd_n,
    output capture_wiring,
    input eoc_n,
    input busy,
    input data
  );
endinterface
`default_nettype wire

// ==== src/qadc_pin_sync.sv ====
// Three-stage pin synchroniser; the output moves only once stages two and three agree.
// Assumes the inputs are asynchronous pins; reset value is a constant parameter.
`timescale 1ns/1ps
`default_nettype none
module qadc_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Stage one feeds only stage two, so no logic sees a metastable value.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Per-bit agreement filter.
  for (genvar i = 0; i < WIDTH; i++) begin : g_agree
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        level[i] <= RST_VAL[i];
      end else if (stage2[i] == stage3[i]) begin
        level[i] <= stage3[i];
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/qadc_conv.sv ====
// Converter end: holds all channels on a start edge, converts the selected ones in turn,
// strobes end-of-conversion per channel and serves results on the parallel bus.
// Assumes link inputs are asynchronous pins and the host meets the strobe timing.
`timescale 1ns/1ps
`default_nettype none
module qadc_conv
  import qadc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  qadc_link_if.device link,
  input wire logic hw_sw_select,
  input wire logic [CH_N-1:0] sw_channels,
  input wire logic [CH_N*DATA_W-1:0] sample_values
);
  typedef enum logic [1:0] {QADC_IDLE, QADC_CONV, QADC_EOC} qadc_conv_state_t;

  qadc_conv_state_t state;
  logic [2:0] pins;
  logic start_s;
  logic cs_s;
  logic rd_s;
  logic start_prev;
  logic rd_act_prev;
  logic start_evt;
  logic rd_act;
  logic [CH_N-1:0] sel_mask;
  logic [CH_IDX_W-1:0] ch;
  logic [CH_IDX_W-1:0] wr_ptr;
  logic [CH_IDX_W-1:0] rd_ptr;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] hold_cnt;
  logic [DATA_W-1:0] held [CH_N];
  logic [DATA_W-1:0] res [CH_N];

  assign pins = {link.conversion_start_n, link.cs_n, link.rd_n};

  qadc_pin_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin(pins),
    .level({start_s, cs_s, rd_s})
  );

  // Edge history of the filtered pins.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      start_prev <= 1'b1;
      rd_act_prev <= 1'b0;
    end else begin
      start_prev <= start_s;
      rd_act_prev <= rd_act;
    end
  end

  assign start_evt = start_s & ~start_prev & (state == QADC_IDLE);
  // read needs chip select and read strobe low.
  assign rd_act = ~cs_s & ~rd_s;

  for (genvar i = 0; i < CH_N; i++) begin : g_hold
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        held[i] <= '0;
      end else if (start_evt) begin
        held[i] <= sample_values[i*DATA_W +: DATA_W];
      end
    end
  end

  // Conversion sequencer; a start edge during a sequence is ignored.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= QADC_IDLE;
      sel_mask <= '0;
      ch <= '0;
      wr_ptr <= '0;
      cnt <= '0;
      link.busy <= 1'b0;
      link.eoc_n <= 1'b1;
    end else begin
      unique case (state)
        QADC_IDLE: begin
          if (start_evt) begin
            sel_mask <= hw_sw_select ? sw_channels : link.channel_select_pins;
            ch <= '0;
            wr_ptr <= '0;
            cnt <= '0;
            link.busy <= 1'b1;
            state <= QADC_CONV;
          end
        end
        QADC_CONV: begin
          if (!sel_mask[ch]) begin
            if (ch == CH_IDX_W'(CH_N - 1)) begin
              link.busy <= 1'b0;
              state <= QADC_IDLE;
            end else begin
              ch <= ch + 1'b1;
            end
          end else if (cnt == CONV_CNT) begin
            res[wr_ptr] <= held[ch];
            wr_ptr <= wr_ptr + 1'b1;
            cnt <= '0;
            link.eoc_n <= 1'b0;
            state <= QADC_EOC;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        QADC_EOC: begin
          if (cnt == EOC_CNT) begin
            cnt <= '0;
            link.eoc_n <= 1'b1;
            if (ch == CH_IDX_W'(CH_N - 1)) begin
              link.busy <= 1'b0;
              state <= QADC_IDLE;
            end else begin
              ch <= ch + 1'b1;
              state <= QADC_CONV;
            end
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      endcase
    end
  end

  // Bus driver: each read takes the next result; data stays driven a little past the strobe
  // so a host that samples on the strobe's rising edge still sees it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_ptr <= '0;
      hold_cnt <= '0;
      link.dev_data <= '0;
      link.dev_data_oe <= 1'b0;
    end else if (start_evt) begin
      rd_ptr <= '0;
      link.dev_data_oe <= 1'b0;
    end else if (rd_act & ~rd_act_prev) begin
      link.dev_data <= res[rd_ptr];
      rd_ptr <= rd_ptr + 1'b1;
      link.dev_data_oe <= 1'b1;
      hold_cnt <= '0;
    end else if (!rd_act && link.dev_data_oe) begin
      if (hold_cnt == HOLD_CNT) begin
        link.dev_data_oe <= 1'b0;
      end else begin
        hold_cnt <= hold_cnt + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/qadc_host.sv ====
// Host end: frame-sync start generator, sequence-done interrupt, strobed bus reader and
// end-strobe capture port, packing 16-bit words in pairs, behind a small register port.
// Assumes the converter end on the link and a software master on the register port.
`timescale 1ns/1ps
`default_nettype none
module qadc_host
  import qadc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  qadc_link_if.host link,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [PACK_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [PACK_W-1:0] reg_rdata,
  output logic irq
);
  typedef enum logic [1:0] {QADC_H_IDLE, QADC_H_RDLO, QADC_H_RDHI} qadc_host_state_t;

  qadc_host_state_t state;
  logic fs_enable;
  logic capture_mode;
  logic fs_running;
  logic addr_step;
  logic capture_hold;
  logic [DIV_W-1:0] fs_div;
  logic [DIV_W-1:0] fs_cnt;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic busy_s;
  logic eoc_s;
  logic busy_prev;
  logic eoc_prev;
  logic seq_evt;
  logic cap_evt;
  logic dma_evt;
  logic word_evt;
  logic xfer_evt;
  logic [WORD_W-1:0] word_in;
  logic [WORD_W-1:0] lo_half;
  logic [CH_IDX_W-1:0] wcnt;
  logic pack_ptr;
  logic [CNT_W-1:0] rd_cnt;
  logic [PACK_W-1:0] packed_mem [2];
  logic [WORD_W-1:0] result [CH_N];
  logic [PACK_W-1:0] next_rdata;
  logic xfer_done_q;

  qadc_pin_sync #(.WIDTH(2), .RST_VAL(2'h1)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin({link.busy, link.eoc_n}),
    .level({busy_s, eoc_s})
  );

  // Edge history of the filtered link inputs; completion trails the final pack write by one.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_prev <= 1'b0;
      eoc_prev <= 1'b1;
      xfer_done_q <= 1'b0;
    end else begin
      busy_prev <= busy_s;
      eoc_prev <= eoc_s;
      xfer_done_q <= xfer_evt;
    end
  end

  assign seq_evt = busy_prev & ~busy_s;
  assign cap_evt = capture_mode & ~capture_hold & eoc_s & ~eoc_prev;
  assign dma_evt = (state == QADC_H_RDLO) && (rd_cnt == RDL_CNT);
  assign word_evt = cap_evt | dma_evt;
  assign word_in = WORD_W'(link.data);
  assign xfer_evt = word_evt && (wcnt == CH_IDX_W'(CH_N - 1));

  // Control registers written by software.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fs_enable <= 1'b0;
      capture_mode <= 1'b0;
      fs_div <= DIV_RESET;
      addr_step <= STEP_RESET;
      mask <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: begin
          fs_enable <= reg_wdata[CTRL_EN_BIT];
          capture_mode <= reg_wdata[CTRL_CAP_BIT];
        end
        REG_DIV: fs_div <= reg_wdata[DIV_W-1:0];
        REG_STEP: addr_step <= reg_wdata[0];
        REG_MASK: mask <= reg_wdata[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // dummy write starts frame sync; dropping the enable stops it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fs_running <= 1'b0;
    end else begin
      fs_running <= fs_enable & (fs_running | (reg_wr && reg_addr == REG_TXBUF));
    end
  end

  // free-running frame sync as start; its low part is fixed, the period is the divider plus one cycles.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fs_cnt <= '0;
      link.conversion_start_n <= 1'b1;
    end else if (!fs_running) begin
      fs_cnt <= '0;
      link.conversion_start_n <= 1'b1;
    end else begin
      fs_cnt <= (fs_cnt >= fs_div) ? '0 : fs_cnt + 1'b1;
      link.conversion_start_n <= (fs_cnt >= FS_LOW_CNT);
    end
  end

  // channel select pins tied high to pick all four channels, capture hold tied low; these are board straps, so plain wires.
  assign link.channel_select_pins = CH_ALL;
  assign link.capture_wiring = capture_mode;
  assign capture_hold = 1'b0;

  // select low for the whole four-word read, read low per word.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= QADC_H_IDLE;
      rd_cnt <= '0;
      link.cs_n <= 1'b1;
      link.host_rd_n <= 1'b1;
    end else begin
      unique case (state)
        QADC_H_IDLE: begin
          link.cs_n <= ~capture_mode;
          rd_cnt <= '0;
          if (seq_evt && !capture_mode) begin
            link.cs_n <= 1'b0;
            link.host_rd_n <= 1'b0;
            state <= QADC_H_RDLO;
          end
        end
        QADC_H_RDLO: begin
          if (rd_cnt == RDL_CNT) begin
            rd_cnt <= '0;
            link.host_rd_n <= 1'b1;
            state <= QADC_H_RDHI;
          end else begin
            rd_cnt <= rd_cnt + 1'b1;
          end
        end
        QADC_H_RDHI: begin
          if (rd_cnt != RDH_CNT) begin
            rd_cnt <= rd_cnt + 1'b1;
          end else if (wcnt == '0) begin
            link.cs_n <= 1'b1;
            state <= QADC_H_IDLE;
          end else begin
            rd_cnt <= '0;
            link.host_rd_n <= 1'b0;
            state <= QADC_H_RDLO;
          end
        end
      endcase
    end
  end

  // pair 16-bit words into one 32-bit word.
  // capture words come on end strobes.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wcnt <= '0;
      pack_ptr <= 1'b0;
      lo_half <= '0;
      packed_mem[0] <= '0;
      packed_mem[1] <= '0;
    end else if (!link.conversion_start_n) begin
      // A new frame restarts packing, so a lost word cannot shift later frames.
      wcnt <= '0;
      pack_ptr <= 1'b0;
    end else if (word_evt) begin
      wcnt <= wcnt + 1'b1;
      if (!wcnt[0]) begin
        lo_half <= word_in;
      end else begin
        packed_mem[pack_ptr] <= {word_in, lo_half};
        pack_ptr <= pack_ptr + addr_step;
      end
    end
  end

  // rearrange once the last word has landed.
  for (genvar i = 0; i < CH_N; i++) begin : g_result
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        result[i] <= '0;
      end else if (xfer_done_q) begin
        result[i] <= packed_mem[i / 2][(i % 2) * WORD_W +: WORD_W];
      end
    end
  end

  // Sticky events: a read of status clears them, a new event in that cycle still sets.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= (reg_rd && reg_addr == REG_STATUS ? '0 : status) | ST_W'({xfer_done_q, seq_evt});
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // Read mux.
  always_comb begin
    unique case (reg_addr)
      REG_CTRL: next_rdata = PACK_W'({fs_running, capture_mode, fs_enable});
      REG_DIV: next_rdata = PACK_W'(fs_div);
      REG_STEP: next_rdata = PACK_W'(addr_step);
      REG_STATUS: next_rdata = PACK_W'(status);
      REG_MASK: next_rdata = PACK_W'(mask);
      REG_RES0: next_rdata = PACK_W'(result[0]);
      REG_RES1: next_rdata = PACK_W'(result[1]);
      REG_RES2: next_rdata = PACK_W'(result[2]);
      REG_RES3: next_rdata = PACK_W'(result[3]);
      default: next_rdata = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : '0;
    end
  end
endmodule
`default_nettype wire

// ==== sim/qadc_link_monitor.sv ====
// Concurrent checks on the converter-to-host link wiring.
// Assumes one core_clk domain and the interface signals wired in as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module qadc_link_monitor
  import qadc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic conversion_start_n,
  input wire logic [CH_N-1:0] channel_select_pins,
  input wire logic cs_n,
  input wire logic host_rd_n,
  input wire logic capture_wiring,
  input wire logic eoc_n,
  input wire logic busy,
  input wire logic [DATA_W-1:0] dev_data,
  input wire logic dev_data_oe,
  input wire logic rd_n,
  input wire logic [DATA_W-1:0] data
);
  localparam int BUSY_MAX = 600;
  logic [11:0] busy_cnt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Counts the length of a sequence, so a stuck busy is caught without a long repetition.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_cnt <= 12'h000;
    end else begin
      busy_cnt <= busy ? busy_cnt + 12'h001 : 12'h000;
    end
  end

  a_start_begins_busy: assert property ($rose(conversion_start_n) && !busy |-> ##[1:12] busy)
    else $error("start edge did not begin a sequence");
  a_eoc_pulse_width: assert property ($fell(eoc_n) |-> (!eoc_n)[*8])
    else $error("end strobe too short");
  a_eoc_within_busy: assert property (!eoc_n |-> busy)
    else $error("end strobe outside the sequence");
  a_busy_bounded_len: assert property (busy_cnt <= 12'(BUSY_MAX))
    else $error("busy held too long");
  a_busy_ends_released: assert property ($fell(busy) |-> eoc_n)
    else $error("busy fell during an end strobe");
  a_oe_needs_select: assert property ($rose(dev_data_oe) |-> !cs_n)
    else $error("bus driven without chip select");
  a_pins_all_four: assert property (channel_select_pins == CH_ALL)
    else $error("channel pins not all selected");
  a_start_pulse_len: assert property ($fell(conversion_start_n) |->
    (!conversion_start_n)[*5] ##1 conversion_start_n)
    else $error("frame sync pulse width wrong");
  a_read_after_busy: assert property (!capture_wiring && !host_rd_n |-> !cs_n && !busy)
    else $error("parallel read outside select or during busy");
  a_capture_strobe: assert property (capture_wiring |-> rd_n == eoc_n && (!busy || !cs_n))
    else $error("capture wiring strobe or select wrong");

  c_sequence: cover property ($fell(busy));
  c_capture_eoc: cover property (capture_wiring && $rose(eoc_n));
  c_parallel_read: cover property (!capture_wiring && $fell(host_rd_n));
endmodule
`default_nettype wire

// ==== sim/quad_adc_conversion_readout_tb.sv ====
// Self-checking bench: both ends joined on the link, host driven over its register port.
// Assumes the package register map and a 250 MHz core_clk.
`timescale 1ns/1ps
`default_nettype none
module quad_adc_conversion_readout_tb;
  import qadc_pkg::*;
  logic core_clk;
  logic rst;
  logic [ADDR_W-1:0] reg_addr;
  logic [PACK_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [PACK_W-1:0] reg_rdata;
  logic irq;
  logic [CH_N*DATA_W-1:0] sample_values;
  int error_cnt;
  int n_compared;

  qadc_link_if qadc_link_if_inst ();
  qadc_conv qadc_conv_inst (.core_clk(core_clk), .rst(rst), .link(qadc_link_if_inst),
    .hw_sw_select(1'b0), .sw_channels(4'h0), .sample_values(sample_values));
  qadc_host qadc_host_inst (.core_clk(core_clk), .rst(rst), .link(qadc_link_if_inst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  qadc_link_monitor qadc_link_monitor_inst (.core_clk(core_clk), .rst(rst),
    .conversion_start_n(qadc_link_if_inst.conversion_start_n),
    .channel_select_pins(qadc_link_if_inst.channel_select_pins),
    .cs_n(qadc_link_if_inst.cs_n), .host_rd_n(qadc_link_if_inst.host_rd_n),
    .capture_wiring(qadc_link_if_inst.capture_wiring), .eoc_n(qadc_link_if_inst.eoc_n),
    .busy(qadc_link_if_inst.busy), .dev_data(qadc_link_if_inst.dev_data),
    .dev_data_oe(qadc_link_if_inst.dev_data_oe), .rd_n(qadc_link_if_inst.rd_n),
    .data(qadc_link_if_inst.data));

  // Free-running 4 ns clock.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compared=%0d mismatches=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [PACK_W-1:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [PACK_W-1:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Reset values, an unmapped place, and a frame period longer than a sequence.
  task automatic reset_values();
    logic [PACK_W-1:0] d;
    rd(REG_DIV, d);
    check(d, 32'h0000_0100);
    rd(REG_STEP, d);
    check(d, 32'h0000_0001);
    rd(8'h30, d);
    check(d, 32'h0000_0000);
    wr(REG_DIV, 32'h0000_0800);
    rd(REG_DIV, d);
    check(d, 32'h0000_0800);
  endtask

  // One started sequence in the chosen scheme; results and status judged afterwards.
  task automatic seq_check(input logic [1:0] ctrl, input logic [CH_N*DATA_W-1:0] s,
                           input logic [ST_W-1:0] mask);
    logic [PACK_W-1:0] d;
    logic [PACK_W-1:0] acc;
    int i;
    acc = '0;
    sample_values <= s;
    wr(REG_MASK, {30'h0, mask});
    wr(REG_CTRL, {30'h0, ctrl});
    wr(REG_TXBUF, 32'h0000_0000);
    for (i = 0; i < 4000 && irq !== 1'b1 && !acc[ST_XFER_BIT]; i++) begin
      if (mask == '0) begin
        rd(REG_STATUS, d);
        acc = acc | d;
      end else begin
        @(posedge core_clk);
      end
    end
    wr(REG_CTRL, {30'h0, ctrl & 2'h2});
    if (i == 4000) begin
      error_cnt++;
      close_out();
    end
    check(irq, mask != '0);
    // A sequence-done interrupt comes before the bus read ends, so poll for both events.
    for (i = 0; i < 200 && acc[ST_W-1:0] !== 2'h3; i++) begin
      rd(REG_STATUS, d);
      acc = acc | d;
    end
    check(acc[ST_W-1:0], 2'h3);
    rd(REG_STATUS, d);
    check(d, 32'h0000_0000);
    check(irq, 1'b0);
    for (int k = 0; k < CH_N; k++) begin
      rd(REG_RES0 + 8'(4 * k), d);
      check(d, {18'h0, s[DATA_W*k +: DATA_W]});
    end
  endtask

  initial begin
    error_cnt = 0;
    n_compared = 0;
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sample_values = '0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    reset_values();
    seq_check(2'h1, {14'h3fff, 14'h0001, 14'h2aaa, 14'h1555}, 2'h2);
    seq_check(2'h3, {14'h0123, 14'h3ffe, 14'h2000, 14'h0000}, 2'h0);
    seq_check(2'h1, {14'h1c3a, 14'h05a5, 14'h3c3c, 14'h2001}, 2'h1);
    close_out();
  end
endmodule
`default_nettype wire
